// ==== verilog/port_queue_policing_map.vh ====
// Register offsets, field positions, reset values and timing counts
`ifndef PORT_QUEUE_POLICING_MAP_VH
`define PORT_QUEUE_POLICING_MAP_VH

`define OFF_PORT_POINTER        12'h804
`define OFF_POLICING_CONTROL    12'h80c
`define OFF_QUEUE_RATE          12'h820
`define OFF_QUEUE_BURST         12'h824
`define OFF_PM_THRESHOLDS       12'h830
`define OFF_PM_PROBABILITY      12'h834
`define OFF_EVENT_MONITOR       12'h848

`define CTL_ENABLE              0
`define CTL_COLOR_BLIND         1
`define CTL_DROP_SRP            2
`define CTL_REMAP_ENABLE        3
`define CTL_MARK_ENABLE         4
`define CTL_NONIP_LO            5
`define CTL_NONIP_HI            6
`define CTL_PORT_BASED          7
`define CTL_MON_LO              8
`define CTL_MON_HI              9
`define CTL_DROP_ALL            10
`define CTL_DROPPED_COLOR       11
`define CTL_WIDTH               12
`define CTL_RESET               12'h020

`define PTR_PORT_LO             16
`define PTR_PORT_HI             18
`define PTR_QUEUE_LO            0
`define PTR_QUEUE_HI            1

`define HI_LO                   16
`define HI_HI                   31
`define LO_HI                   15
`define TH_HI_LO                16
`define TH_HI_HI                26
`define TH_LO_HI                10

`define CIR_RESET               16'h1000
`define PIR_RESET               16'h2000
`define CBS_RESET               16'h1000
`define PBS_RESET               16'h3000
`define PM_MAX_RESET            11'h400
`define PM_MIN_RESET            11'h080
`define PM_SCALE_RESET          11'h020

`define COLOR_GREEN             2'h1
`define COLOR_YELLOW            2'h2
`define COLOR_RED               2'h3

`define MON_DROPPED             2'h0
`define MON_GREEN               2'h1
`define MON_YELLOW              2'h2
`define MON_RED                 2'h3

`define CLK_PERIOD_NS           25
`define REFILL_NS               25000
`define REFILL_CYCLES           (`REFILL_NS / `CLK_PERIOD_NS)

`endif

// ==== verilog/port_queue_policing_wred_config.v ====
// Per-port policing and packet-memory drop configuration with APB registers
//
// Behaviour
// RQ1: Enable bit turns policing and WRED on.
// RQ2: Bit 1 picks color-blind or color-aware.
// RQ3: Bit 2 allows dropping stream reservation packets.
// RQ4: Bit 3 remaps color, else DSCP color.
// RQ5: Bit 4 enables marking color into DSCP.
// RQ6: Bits 6:5 color non-IP frames, reset 01.
// RQ7: Bit 7 per-port-queue or per-queue policing.
// RQ8: Per-queue mode uses port index 0 rates.
// RQ9: Bits 9:8 choose monitor count read.
// RQ10: Bit 10 drops all above maximum threshold.
// RQ11: Bit 11 counts only dropped packets per color.
// RQ12: Rate upper half committed rate, reset 1000.
// RQ13: Rate lower half peak rate, reset 2000.
// RQ14: Burst upper half committed burst, reset 1000.
// RQ15: Burst lower half peak burst, reset 3000.
// RQ16: Memory maximum threshold bits 26:16, reset 400.
// RQ17: Memory minimum threshold bits 10:0, reset 080.
// RQ18: Port index and queue pointer select entry.
// RQ19: Probability scale bits 26:16, reset 020.
// RQ20: Reserved bits read zero, ignore writes.
// RQ21: Two buckets grade green, yellow, red.
// RQ22: Drop probability rises between the thresholds.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "port_queue_policing_map.vh"

module port_queue_policing_wred_config (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        pktValid,
    input  wire [2:0]  pktPort,
    input  wire [1:0]  pktQueue,
    input  wire [15:0] pktLength,
    input  wire        pktIsIp,
    input  wire        pktIsSrp,
    input  wire [1:0]  pktDscpColor,
    input  wire [1:0]  pktRemapColor,
    input  wire [10:0] memAverageLevel,
    output reg         decisionValid,
    output reg         decisionDrop,
    output reg  [1:0]  decisionColor,
    output reg         decisionMarkDscp,
    output reg         policingActive
);

    reg [`CTL_WIDTH-1:0] control;
    reg [2:0]            portIndex;
    reg [1:0]            queuePointer;
    reg [10:0]           pmMaxThreshold;
    reg [10:0]           pmMinThreshold;
    reg [10:0]           memoryDropProbabilityScale;
    reg [10:0]           levelSeen;
    reg [15:0]           lfsr;
    reg [9:0]            refillCount;
    reg                  refillPending;

    // Indexed by {port, queue}; eight port slots keep decoding trivial
    reg [31:0] rateTable  [0:31];
    reg [31:0] burstTable [0:31];
    reg [15:0] committedTokens [0:31];
    reg [15:0] peakTokens      [0:31];
    // Indexed by {count kind, port, queue}
    reg [23:0] monitorCount [0:127];

    integer i;
    integer j;
    integer k;

    function [15:0] refill;
        input [15:0] tokens;
        input [15:0] rate;
        input [15:0] limit;
        reg   [16:0] sum;
        begin
            sum = {1'b0, tokens} + {1'b0, rate};
            if (sum > {1'b0, limit}) begin
                refill = limit;
            end else begin
                refill = sum[15:0];
            end
        end
    endfunction

    function [4:0] entryIndex;
        input       portBased;
        input [2:0] port;
        input [1:0] queue;
        begin
            // RQ8 shared index zero
            entryIndex = portBased ? {port, queue} : {3'h0, queue};
        end
    endfunction

    function [6:0] counterIndex;
        input [1:0] kind;
        input [4:0] slot;
        begin
            counterIndex = {kind, slot};
        end
    endfunction

    // APB decode
    wire [11:0] offset     = paddr[11:0];
    wire        setupPhase = psel && !penable;
    wire        writeTake  = psel && penable && pwrite;
    wire        hitPointer = (offset == `OFF_PORT_POINTER);
    wire        hitControl = (offset == `OFF_POLICING_CONTROL);
    wire        hitRate    = (offset == `OFF_QUEUE_RATE);
    wire        hitBurst   = (offset == `OFF_QUEUE_BURST);
    wire        hitThresh  = (offset == `OFF_PM_THRESHOLDS);
    wire        hitProb    = (offset == `OFF_PM_PROBABILITY);
    wire        hitMonitor = (offset == `OFF_EVENT_MONITOR);
    wire        mapped     = hitPointer || hitControl || hitRate || hitBurst ||
                             hitThresh || hitProb || hitMonitor;
    // RQ18 software-selected entry
    wire [4:0]  swEntry    = {portIndex, queuePointer};
    wire [6:0]  monEntry   = counterIndex(control[`CTL_MON_HI:`CTL_MON_LO], swEntry);

    // Zero wait states; unmapped offsets answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // One write strobe per register except the read-only event monitor
    wire        writePointer = writeTake && hitPointer;
    wire        writeControl = writeTake && hitControl;
    wire        writeRate    = writeTake && hitRate;
    wire        writeBurst   = writeTake && hitBurst;
    wire        writeThresh  = writeTake && hitThresh;
    wire        writeProb    = writeTake && hitProb;

    // Packet path, combinational part
    wire        enabled     = control[`CTL_ENABLE];
    // RQ7 granularity select
    wire [4:0]  pktEntry    = entryIndex(control[`CTL_PORT_BASED], pktPort, pktQueue);
    wire [15:0] cirTokens   = committedTokens[pktEntry];
    wire [15:0] pirTokens   = peakTokens[pktEntry];
    wire        fitsCommit  = pktLength <= cirTokens;
    wire        fitsPeak    = pktLength <= pirTokens;

    reg [1:0] inputColor;
    reg [1:0] meterColor;
    always @* begin
        // RQ6 non-IP color
        if (!pktIsIp) begin
            inputColor = control[`CTL_NONIP_HI:`CTL_NONIP_LO];
        // RQ4 remap or direct
        end else if (control[`CTL_REMAP_ENABLE]) begin
            inputColor = pktRemapColor;
        end else begin
            inputColor = pktDscpColor;
        end
        // RQ21 two-bucket grading
        if (fitsCommit && fitsPeak) begin
            meterColor = `COLOR_GREEN;
        end else if (fitsPeak) begin
            meterColor = `COLOR_YELLOW;
        end else begin
            meterColor = `COLOR_RED;
        end
        // RQ2 color-aware never upgrades
        if (!control[`CTL_COLOR_BLIND] && inputColor > meterColor) begin
            meterColor = inputColor;
        end
    end

    // RQ22 probability grows with depth past minimum
    wire        belowMin  = memAverageLevel < pmMinThreshold;
    wire        aboveMax  = memAverageLevel > pmMaxThreshold;
    wire [10:0] depth     = memAverageLevel - pmMinThreshold;
    // A zero scale turns off the random drops
    wire [21:0] dropOdds  = depth * memoryDropProbabilityScale;
    wire        randomHit = dropOdds > {6'h00, lfsr};
    reg         wredDrop;
    always @* begin
        if (belowMin) begin
            wredDrop = 1'b0;
        // RQ10 drop all or scaled
        end else if (aboveMax && control[`CTL_DROP_ALL]) begin
            wredDrop = 1'b1;
        end else begin
            wredDrop = randomHit;
        end
    end

    // RQ3 stream reservation protection
    wire srpShield = pktIsSrp && !control[`CTL_DROP_SRP];
    // RQ1 one enable for both functions
    wire dropNow   = enabled && !srpShield &&
                     (meterColor == `COLOR_RED || wredDrop);

    // Register file and software reads
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            control                    <= `CTL_RESET;
            portIndex                  <= 3'h0;
            queuePointer               <= 2'h0;
            pmMaxThreshold             <= `PM_MAX_RESET;
            pmMinThreshold             <= `PM_MIN_RESET;
            memoryDropProbabilityScale <= `PM_SCALE_RESET;
            prdata                     <= 32'h00000000;
        end else begin
            if (writeControl) begin
                control <= pwdata[`CTL_WIDTH-1:0];
            end
            if (writePointer) begin
                portIndex    <= pwdata[`PTR_PORT_HI:`PTR_PORT_LO];
                queuePointer <= pwdata[`PTR_QUEUE_HI:`PTR_QUEUE_LO];
            end
            if (writeThresh) begin
                // RQ16 maximum threshold
                pmMaxThreshold <= pwdata[`TH_HI_HI:`TH_HI_LO];
                // RQ17 minimum threshold
                pmMinThreshold <= pwdata[`TH_LO_HI:0];
            end
            // RQ19 probability scale
            if (writeProb) begin
                memoryDropProbabilityScale <= pwdata[`TH_HI_HI:`TH_HI_LO];
            end
            // Read data captured in setup so it is steady in access
            if (setupPhase) begin
                prdata <= 32'h00000000;
                // RQ20 reserved bits zero
                if (hitControl) begin
                    prdata <= {20'h00000, control};
                end
                if (hitPointer) begin
                    prdata <= {13'h0, portIndex, 14'h0, queuePointer};
                end
                if (hitRate) begin
                    prdata <= rateTable[swEntry];
                end
                if (hitBurst) begin
                    prdata <= burstTable[swEntry];
                end
                if (hitThresh) begin
                    prdata <= {5'h00, pmMaxThreshold, 5'h00, pmMinThreshold};
                end
                if (hitProb) begin
                    prdata <= {5'h00, memoryDropProbabilityScale, 5'h00, levelSeen};
                end
                // RQ9 selected monitor count
                if (hitMonitor) begin
                    prdata <= {8'h00, monitorCount[monEntry]};
                end
            end
        end
    end

    // Rate and burst tables
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < 32; i = i + 1) begin
                // RQ12 RQ13 rate reset values
                rateTable[i]  <= {`CIR_RESET, `PIR_RESET};
                // RQ14 RQ15 burst reset values
                burstTable[i] <= {`CBS_RESET, `PBS_RESET};
            end
        end else begin
            if (writeRate) begin
                rateTable[swEntry] <= pwdata;
            end
            if (writeBurst) begin
                burstTable[swEntry] <= pwdata;
            end
        end
    end

    // Refill timer; a refill waits for a cycle without a packet
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            refillCount   <= 10'h000;
            refillPending <= 1'b0;
        end else begin
            if (refillCount == `REFILL_CYCLES - 1) begin
                refillCount   <= 10'h000;
                refillPending <= 1'b1;
            end else begin
                refillCount <= refillCount + 10'h001;
                if (!pktValid) begin
                    refillPending <= 1'b0;
                end
            end
        end
    end

    // Token buckets
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (j = 0; j < 32; j = j + 1) begin
                committedTokens[j] <= `CBS_RESET;
                peakTokens[j]      <= `PBS_RESET;
            end
        end else if (refillPending && !pktValid) begin
            for (j = 0; j < 32; j = j + 1) begin
                committedTokens[j] <= refill(committedTokens[j],
                                             rateTable[j][`HI_HI:`HI_LO],
                                             burstTable[j][`HI_HI:`HI_LO]);
                peakTokens[j]      <= refill(peakTokens[j],
                                             rateTable[j][`LO_HI:0],
                                             burstTable[j][`LO_HI:0]);
            end
        // Dropped packets spend nothing, so a queue recovers
        // RQ21 spend tokens by grade
        end else if (pktValid && enabled && !dropNow) begin
            if (meterColor == `COLOR_GREEN) begin
                committedTokens[pktEntry] <= cirTokens - pktLength;
            end
            if (meterColor != `COLOR_RED) begin
                peakTokens[pktEntry] <= pirTokens - pktLength;
            end
        end
    end

    // Event monitor counters, kept per physical port and queue
    // Counts wrap at 24 bits; software works with differences
    wire [4:0] pktSlot  = {pktPort, pktQueue};
    wire [6:0] colorCnt = counterIndex(meterColor, pktSlot);
    wire [6:0] dropCnt  = counterIndex(`MON_DROPPED, pktSlot);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (k = 0; k < 128; k = k + 1) begin
                monitorCount[k] <= 24'h000000;
            end
        end else if (pktValid && enabled) begin
            // RQ11 dropped-only or all
            if (dropNow || !control[`CTL_DROPPED_COLOR]) begin
                monitorCount[colorCnt] <= monitorCount[colorCnt] + 24'h000001;
            end
            if (dropNow) begin
                monitorCount[dropCnt] <= monitorCount[dropCnt] + 24'h000001;
            end
        end
    end

    // Maximal-length taps; the draw repeats only after 65535 cycles
    wire lfsrFeedback = lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10];

    // Random source and decision outputs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lfsr             <= 16'hace1;
            levelSeen        <= 11'h000;
            decisionValid    <= 1'b0;
            decisionDrop     <= 1'b0;
            decisionColor    <= `COLOR_GREEN;
            decisionMarkDscp <= 1'b0;
            policingActive   <= 1'b0;
        end else begin
            lfsr           <= {lfsr[14:0], lfsrFeedback};
            levelSeen      <= memAverageLevel;
            decisionValid  <= pktValid;
            policingActive <= enabled;
            if (pktValid) begin
                // RQ1 disabled passes everything green
                decisionDrop     <= dropNow;
                decisionColor    <= enabled ? meterColor : `COLOR_GREEN;
                // RQ5 DSCP color marking
                decisionMarkDscp <= enabled && control[`CTL_MARK_ENABLE];
            end
        end
    end

endmodule

// ==== verif/port_queue_policing_sva.sv ====
// Concurrent checks on the policing and drop configuration ports
`timescale 1ns/1ps
`include "port_queue_policing_map.vh"
module port_queue_policing_sva (
    input wire        clk,
    input wire        rst_b,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        pktValid,
    input wire [2:0]  pktPort,
    input wire [1:0]  pktQueue,
    input wire [15:0] pktLength,
    input wire        pktIsIp,
    input wire        pktIsSrp,
    input wire [1:0]  pktDscpColor,
    input wire [1:0]  pktRemapColor,
    input wire [10:0] memAverageLevel,
    input wire        decisionValid,
    input wire        decisionDrop,
    input wire [1:0]  decisionColor,
    input wire        decisionMarkDscp,
    input wire        policingActive
);
    // Shadow of the control word, so packet checks know the mode
    reg  [11:0] ctl;
    wire [11:0] off = paddr[11:0];
    wire        hit = off == `OFF_PORT_POINTER || off == `OFF_POLICING_CONTROL ||
                      off == `OFF_QUEUE_RATE || off == `OFF_QUEUE_BURST ||
                      off == `OFF_PM_THRESHOLDS || off == `OFF_PM_PROBABILITY ||
                      off == `OFF_EVENT_MONITOR;
    wire [1:0]  inColor = !pktIsIp ? ctl[6:5] : (ctl[3] ? pktRemapColor : pktDscpColor);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            ctl <= `CTL_RESET;
        else if (psel && penable && pwrite && off == `OFF_POLICING_CONTROL)
            ctl <= pwdata[11:0];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_decision_pulse: assert property (decisionValid == $past(pktValid))
        else $error("decision strobe not one cycle after packet");
    a_decision_hold: assert property (
        !pktValid |=> $stable(decisionDrop) && $stable(decisionColor))
        else $error("decision changed without a packet");
    a_disabled_pass: assert property (
        pktValid && !ctl[0] |=> !decisionDrop && decisionColor == `COLOR_GREEN)
        else $error("disabled block altered a packet");
    a_active_copy: assert property ($stable(ctl[0]) |-> policingActive == ctl[0])
        else $error("active flag differs from enable bit");
    a_srp_kept: assert property (pktValid && pktIsSrp && !ctl[2] |=> !decisionDrop)
        else $error("protected reservation packet dropped");
    a_mark_follows: assert property (
        pktValid && ctl[0] |=> decisionMarkDscp == $past(ctl[4]))
        else $error("marking flag differs from mark bit");
    a_aware_red: assert property (
        pktValid && ctl[0] && !ctl[1] && inColor == `COLOR_RED |=> decisionColor == `COLOR_RED)
        else $error("aware mode lost the incoming red");
    a_red_drops: assert property (
        pktValid && ctl[0] && !pktIsSrp |=> decisionColor != `COLOR_RED || decisionDrop)
        else $error("red packet not dropped");
    a_slave_error: assert property (pslverr == (psel && penable && !hit))
        else $error("slave error does not match decode");
    a_ctl_readback: assert property (
        psel && !penable && !pwrite && off == `OFF_POLICING_CONTROL |=>
        prdata == {20'h0, $past(ctl)})
        else $error("control read differs from written word");

    cover property (pktValid && ctl[0] && !ctl[1]);
    cover property (decisionValid && decisionDrop);
    cover property (psel && penable && pslverr);
endmodule

bind port_queue_policing_wred_config port_queue_policing_sva chk (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pktValid, .pktPort, .pktQueue, .pktLength, .pktIsIp, .pktIsSrp, .pktDscpColor,
    .pktRemapColor, .memAverageLevel, .decisionValid, .decisionDrop, .decisionColor,
    .decisionMarkDscp, .policingActive
);

// ==== verif/tb_top.sv ====
// Self-checking bench for the policing and drop configuration block
`timescale 1ns/1ps
`include "port_queue_policing_map.vh"
module tb_top;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
    logic [15:0] paddr, pktLength;
    logic [31:0] pwdata, prdata, rd;
    logic        pktValid, pktIsIp, pktIsSrp, decisionValid, decisionDrop;
    logic        decisionMarkDscp, policingActive;
    logic [2:0]  pktPort;
    logic [1:0]  pktQueue, pktDscpColor, pktRemapColor, decisionColor;
    logic [10:0] memAverageLevel;
    int          errCount, checksDone, i;
    logic [11:0] offs [7] = '{`OFF_PORT_POINTER, `OFF_POLICING_CONTROL, `OFF_QUEUE_RATE,
        `OFF_QUEUE_BURST, `OFF_PM_THRESHOLDS, `OFF_PM_PROBABILITY, `OFF_EVENT_MONITOR};
    logic [31:0] rstv [7] = '{32'h0, 32'h20, 32'h10002000, 32'h10003000, 32'h04000080,
        32'h00200010, 32'h0};
    logic [31:0] onesv [7] = '{32'h00070003, 32'hfff, 32'hffffffff, 32'hffffffff,
        32'h07ff07ff, 32'h07ff0010, 32'h0};
    // Dropped, green, yellow, red counts after the metering run
    logic [31:0] monv [4] = '{32'h1, 32'h1, 32'h2, 32'h1};

    port_queue_policing_wred_config uut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pktValid(pktValid), .pktPort(pktPort), .pktQueue(pktQueue), .pktLength(pktLength),
        .pktIsIp(pktIsIp), .pktIsSrp(pktIsSrp), .pktDscpColor(pktDscpColor),
        .pktRemapColor(pktRemapColor), .memAverageLevel(memAverageLevel),
        .decisionValid(decisionValid), .decisionDrop(decisionDrop),
        .decisionColor(decisionColor), .decisionMarkDscp(decisionMarkDscp),
        .policingActive(policingActive));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, exp, msk);
        checksDone++;
        if ((got & msk) !== (exp & msk)) begin
            errCount++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Top nibble carries a port number, which this slice ignores
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {4'h1, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pkt(input logic [2:0] p, input logic [15:0] len, input logic ip, srp,
                       input logic dr, input logic [1:0] col);
        @(posedge clk);
        pktValid <= 1'b1;
        pktPort <= p;
        pktLength <= len;
        pktIsIp <= ip;
        pktIsSrp <= srp;
        @(posedge clk);
        pktValid <= 1'b0;
        #1;
        chk({decisionValid, decisionDrop, decisionColor}, {1'b1, dr, col}, 32'hf);
    endtask

    task automatic stopTest;
        $display("errors %0d checks %0d", errCount, checksDone);
        if (errCount == 0 && checksDone > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #(4000 * 25);
        errCount++;
        stopTest();
    end

    initial begin
        {psel, penable, pwrite, pktValid, pktIsIp, pktIsSrp} = '0;
        paddr = '0;
        pwdata = '0;
        pktPort = '0;
        pktQueue = '0;
        pktLength = '0;
        pktDscpColor = `COLOR_GREEN;
        pktRemapColor = `COLOR_RED;
        memAverageLevel = 11'h010;
        errCount = 0;
        checksDone = 0;
        rst_b = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 7; i++) begin
            apb(1'b0, offs[i], 32'h0);
            chk(rd, rstv[i], 32'hffffffff);
        end
        // Buckets start full; runs well before the first refill
        pkt(3'h3, 16'h0f00, 1'b1, 1'b0, 1'b0, `COLOR_GREEN);
        chk({30'h0, policingActive, decisionMarkDscp}, 32'h0, 32'h3);
        apb(1'b1, `OFF_POLICING_CONTROL, 32'h3);
        pkt(3'h3, 16'h0f00, 1'b1, 1'b0, 1'b0, `COLOR_GREEN);
        chk({30'h0, policingActive, decisionMarkDscp}, 32'h2, 32'h3);
        pkt(3'h3, 16'h0f00, 1'b1, 1'b0, 1'b0, `COLOR_YELLOW);
        pkt(3'h3, 16'h0f00, 1'b1, 1'b0, 1'b0, `COLOR_YELLOW);
        pkt(3'h3, 16'h0f00, 1'b1, 1'b0, 1'b1, `COLOR_RED);
        apb(1'b1, `OFF_PORT_POINTER, 32'h00030000);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `OFF_POLICING_CONTROL, {22'h0, i[1:0], 8'h03});
            apb(1'b0, `OFF_EVENT_MONITOR, 32'h0);
            chk(rd, monv[i], 32'hffffffff);
        end
        apb(1'b1, `OFF_POLICING_CONTROL, 32'h83);
        pkt(3'h3, 16'h0f00, 1'b1, 1'b0, 1'b0, `COLOR_GREEN);
        apb(1'b1, `OFF_POLICING_CONTROL, 32'hc83);
        memAverageLevel <= 11'h7ff;
        pkt(3'h4, 16'h1, 1'b1, 1'b1, 1'b0, `COLOR_GREEN);
        pkt(3'h4, 16'h1, 1'b1, 1'b0, 1'b1, `COLOR_GREEN);
        apb(1'b1, `OFF_POLICING_CONTROL, 32'hc87);
        pkt(3'h4, 16'h1, 1'b1, 1'b1, 1'b1, `COLOR_GREEN);
        memAverageLevel <= 11'h010;
        pkt(3'h4, 16'h1, 1'b1, 1'b0, 1'b0, `COLOR_GREEN);
        // Dropped-only counting: two of the four green packets were dropped
        apb(1'b1, `OFF_PORT_POINTER, 32'h00040000);
        apb(1'b1, `OFF_POLICING_CONTROL, 32'hd87);
        apb(1'b0, `OFF_EVENT_MONITOR, 32'h0);
        chk(rd, 32'h2, 32'hffffffff);
        // Reservation flag keeps the red outcome from dropping
        apb(1'b1, `OFF_POLICING_CONTROL, 32'hf1);
        pkt(3'h5, 16'h1, 1'b0, 1'b1, 1'b0, `COLOR_RED);
        chk({30'h0, policingActive, decisionMarkDscp}, 32'h3, 32'h3);
        pkt(3'h5, 16'h1, 1'b1, 1'b1, 1'b0, `COLOR_GREEN);
        apb(1'b1, `OFF_POLICING_CONTROL, 32'hf9);
        pkt(3'h5, 16'h1, 1'b1, 1'b1, 1'b0, `COLOR_RED);
        apb(1'b1, `OFF_PORT_POINTER, 32'h00020003);
        apb(1'b1, `OFF_QUEUE_RATE, 32'h12345678);
        apb(1'b1, `OFF_PORT_POINTER, 32'h00020001);
        apb(1'b0, `OFF_QUEUE_RATE, 32'h0);
        chk(rd, 32'h10002000, 32'hffffffff);
        apb(1'b1, `OFF_PORT_POINTER, 32'h00020003);
        apb(1'b0, `OFF_QUEUE_RATE, 32'h0);
        chk(rd, 32'h12345678, 32'hffffffff);
        for (i = 0; i < 7; i++) begin
            apb(1'b1, offs[i], 32'hffffffff);
            apb(1'b0, offs[i], 32'h0);
            chk(rd, onesv[i], 32'hffffffff);
        end
        apb(1'b1, 12'h810, 32'hffffffff);
        chk({31'h0, er}, 32'h1, 32'h1);
        apb(1'b0, 12'h810, 32'h0);
        chk(rd, 32'h0, 32'hffffffff);
        stopTest();
    end
endmodule
